// ### pkg/term_ctrl_pkg.sv
// types shared by the termination control block
package term_ctrl_pkg;

	typedef enum logic [3:0]
	{
		TERM_OFF = 4'b0001,
		TERM_PARK = 4'b0010,
		TERM_NOM = 4'b0100,
		TERM_WR = 4'b1000
	} term_state_e;

	typedef enum logic [1:0]
	{
		BURST_FIXED_FULL = 2'h0,
		BURST_ON_FLY = 2'h1,
		BURST_FIXED_CHOP = 2'h2
	} burst_mode_e;

	typedef struct packed
	{
		logic write;
		logic read;
		logic chop;
	} cmd_s;

	typedef struct packed
	{
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

endpackage : term_ctrl_pkg

// ### pkg/term_ctrl_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef TERM_CTRL_REGS_SVH
`define TERM_CTRL_REGS_SVH

// register offsets
`define REG_MODE_ONE 4'h0
`define REG_MODE_TWO 4'h1
`define REG_MODE_FIVE 4'h2
`define REG_LATENCY 4'h3
`define REG_CONFIG 4'h4
`define REG_STATUS 4'h5

// mode register fields
`define MODE_ONE_DLL_BIT 0
`define MODE_ONE_NOM_HI 10
`define MODE_ONE_NOM_LO 8
`define MODE_TWO_WR_HI 10
`define MODE_TWO_WR_LO 9
`define MODE_FIVE_PARK_HI 8
`define MODE_FIVE_PARK_LO 6
`define MODE_FIVE_BUFDIS_BIT 5

// latency register fields
`define LAT_CWL_HI 4
`define LAT_CWL_LO 0
`define LAT_AL_HI 9
`define LAT_AL_LO 5
`define LAT_PL_HI 13
`define LAT_PL_LO 10
`define LAT_CL_HI 19
`define LAT_CL_LO 14

// config register fields
`define CFG_CRC_BIT 0
`define CFG_PRE2_BIT 1
`define CFG_BURST_HI 3
`define CFG_BURST_LO 2

// status register fields
`define STAT_STATE_HI 3
`define STAT_STATE_LO 0
`define STAT_PD_BIT 4
`define STAT_HOLD_BIT 5

// reset values
`define MODE_ONE_RST 16'h0001
`define MODE_TWO_RST 16'h0000
`define MODE_FIVE_RST 16'h0000
`define LATENCY_RST 20'h2c009
`define CONFIG_RST 4'h0

// timing
`define HIST_DEPTH 64
`define CLK_PERIOD_PS 8000
`define ASYNC_ON_MIN_PS 1000
`define ASYNC_OFF_MIN_PS 1000
`define ASYNC_ON_CYC ((`ASYNC_ON_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ASYNC_OFF_CYC ((`ASYNC_OFF_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TERM_HOLD_MIN_CHOP 7'h04
`define TERM_HOLD_MIN_FULL 7'h06

`endif

// ### rtl/term_ctrl.sv
// on-die termination control of the memory device
// Behaviour
// RULE_01 - controller holds pin high for minimum hold
// RULE_02 - hold counted from pin high or write
// RULE_03 - no termination while driving read data
// RULE_04 - write termination fields nonzero enable dynamic switching
// RULE_05 - mode register fields select each termination value
// RULE_06 - pin switches nominal, parked while pin low
// RULE_07 - write selects write termination after select delay
// RULE_08 - write termination released after burst release delay
// RULE_09 - select delay is latency minus two or three
// RULE_10 - chop release is latency plus four or five
// RULE_11 - full release is latency plus six or seven
// RULE_12 - dll off gives undelayed asynchronous mode
// RULE_13 - async turn-on after minimum on time
// RULE_14 - async turn-off after minimum off time
// RULE_15 - buffer disable drops nominal in power-down
// RULE_16 - controller drives pin steady entering power-down
// RULE_17 - pre power-down window samples may be omitted
// RULE_18 - controller holds pin low until exit time
// RULE_19 - sync nominal delay latency minus two or three
// RULE_20 - priority read, write, nominal, parked
// RULE_21 - read disable from latency minus x, half burst plus x plus y
// RULE_22 - pin sampled each rising edge, counts in cycles
`include "term_ctrl_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module term_ctrl
	import term_ctrl_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// device pins
	input wire logic term_ctl_pin_i,
	input wire logic cke_i,
	// decoded commands
	input wire cmd_s cmd_i,
	// register port
	input wire reg_req_s req_i,
	output logic [31:0] rdata_o,
	// termination selection
	output term_state_e term_state_o,
	output logic [2:0] term_value_o
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	localparam int HD = `HIST_DEPTH;

	logic [15:0] mode_one_r;
	logic [15:0] mode_two_r;
	logic [15:0] mode_five_r;
	logic [19:0] latency_r;
	logic [3:0] config_r;
	logic hold_viol_r;
	logic [31:0] rdata_r;

	logic [2:0] pin_sync_r;
	logic pin_f_r;
	logic [2:0] cke_sync_r;
	logic cke_f_r;

	logic [HD-1:0] pin_hist_r;
	logic [HD-1:0] wr_hist_r;
	logic [HD-1:0] wr_chop_hist_r;
	logic [HD-1:0] rd_hist_r;
	logic [HD-1:0] rd_chop_hist_r;

	logic [6:0] hold_cnt_r;
	logic hold_run_r;
	logic hold_chop_r;

	term_state_e state_r;
	term_state_e state_nxt;
	logic [2:0] value_r;
	logic [2:0] value_nxt;

	logic [6:0] wl;
	logic [6:0] rl;
	logic [6:0] xcyc;
	logic [6:0] ycyc;
	logic [6:0] nom_dly;
	logic [6:0] nom_idx;
	logic [6:0] wsel_dly;
	logic [6:0] wrel_chop;
	logic [6:0] wrel_full;
	logic [6:0] rd_start;
	logic [6:0] hold_min;
	logic [2:0] nom_val;
	logic [2:0] park_val;
	logic [2:0] wr_val;
	logic dyn_en;
	logic dll_on;
	logic buf_dis;
	logic crc_en;
	logic pre2;
	logic cmd_chop;
	logic nom_sync;
	logic nom_async;
	logic nom_on;
	logic wr_act;
	logic rd_act;
	logic pin_rise;
	logic pin_fall;

	////////////////////////////////////////////////////////////////////////////
	// field decode

	assign nom_val = mode_one_r[`MODE_ONE_NOM_HI:`MODE_ONE_NOM_LO]; // RULE_05
	assign park_val = mode_five_r[`MODE_FIVE_PARK_HI:`MODE_FIVE_PARK_LO]; // RULE_05
	assign wr_val = {1'b0, mode_two_r[`MODE_TWO_WR_HI:`MODE_TWO_WR_LO]}; // RULE_05
	assign dyn_en = |mode_two_r[`MODE_TWO_WR_HI:`MODE_TWO_WR_LO]; // RULE_04
	assign dll_on = mode_one_r[`MODE_ONE_DLL_BIT]; // RULE_12
	assign buf_dis = mode_five_r[`MODE_FIVE_BUFDIS_BIT];
	assign crc_en = config_r[`CFG_CRC_BIT];
	assign pre2 = config_r[`CFG_PRE2_BIT];

	// chopped burst, fixed or on the fly
	always_comb
	begin
		case (burst_mode_e'(config_r[`CFG_BURST_HI:`CFG_BURST_LO]))
			BURST_FIXED_CHOP: cmd_chop = 1'b1;
			BURST_ON_FLY: cmd_chop = cmd_i.chop;
			default: cmd_chop = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// latencies

	assign wl = 7'(latency_r[`LAT_CWL_HI:`LAT_CWL_LO])
		+ 7'(latency_r[`LAT_AL_HI:`LAT_AL_LO])
		+ 7'(latency_r[`LAT_PL_HI:`LAT_PL_LO]);
	assign rl = 7'(latency_r[`LAT_CL_HI:`LAT_CL_LO])
		+ 7'(latency_r[`LAT_AL_HI:`LAT_AL_LO])
		+ 7'(latency_r[`LAT_PL_HI:`LAT_PL_LO]);
	assign xcyc = pre2 ? 7'h03 : 7'h02; // RULE_21
	assign ycyc = crc_en ? 7'h01 : 7'h00; // RULE_21

	assign nom_dly = (wl > xcyc) ? wl - xcyc : 7'h00; // RULE_19
	assign wsel_dly = (wl > xcyc) ? wl - xcyc : 7'h00; // RULE_09
	assign wrel_chop = wl + 7'h04 + ycyc; // RULE_10
	assign wrel_full = wl + 7'h06 + ycyc; // RULE_11
	assign rd_start = (rl > xcyc) ? rl - xcyc : 7'h00; // RULE_21

	assign hold_min = (hold_chop_r ? `TERM_HOLD_MIN_CHOP : `TERM_HOLD_MIN_FULL)
		+ ycyc + (pre2 ? 7'h01 : 7'h00);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_sync_r <= 3'h0;
			pin_f_r <= 1'b0;
		end
		else
		begin
			pin_sync_r <= {pin_sync_r[1:0], term_ctl_pin_i}; // RULE_22
			if (pin_sync_r[1] == pin_sync_r[2])
				pin_f_r <= pin_sync_r[2];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cke_sync_r <= 3'h0;
			cke_f_r <= 1'b0;
		end
		else
		begin
			cke_sync_r <= {cke_sync_r[1:0], cke_i};
			if (cke_sync_r[1] == cke_sync_r[2])
				cke_f_r <= cke_sync_r[2];
		end
	end

	assign pin_rise = pin_f_r & ~pin_hist_r[0];
	assign pin_fall = ~pin_f_r & pin_hist_r[0];

	////////////////////////////////////////////////////////////////////////////
	// sample and command histories

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_hist_r <= '0;
			wr_hist_r <= '0;
			wr_chop_hist_r <= '0;
			rd_hist_r <= '0;
			rd_chop_hist_r <= '0;
		end
		else
		begin
			// samples during power-down with buffer disabled are dropped
			pin_hist_r <= {pin_hist_r[HD-2:0], pin_f_r & ~(buf_dis & ~cke_f_r)}; // RULE_17
			wr_hist_r <= {wr_hist_r[HD-2:0], cmd_i.write & dyn_en}; // RULE_07
			wr_chop_hist_r <= {wr_chop_hist_r[HD-2:0], cmd_chop};
			rd_hist_r <= {rd_hist_r[HD-2:0], cmd_i.read};
			rd_chop_hist_r <= {rd_chop_hist_r[HD-2:0], cmd_chop};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// nominal termination

	// sync mode delayed by write latency minus two or three, async mode by a fixed short time
	assign nom_idx = (nom_dly == 7'h00) ? 7'h00 : nom_dly - 7'h01;
	assign nom_sync = pin_hist_r[(nom_idx > 7'd63) ? 6'd63 : nom_idx[5:0]]; // RULE_19
	assign nom_async = pin_hist_r[`ASYNC_ON_CYC - 1] & pin_hist_r[`ASYNC_OFF_CYC - 1]; // RULE_13
	assign nom_on = (dll_on ? nom_sync : nom_async) // RULE_12
		& (nom_val != 3'h0)
		& ~(buf_dis & ~cke_f_r); // RULE_15

	////////////////////////////////////////////////////////////////////////////
	// write and read windows

	always_comb
	begin
		wr_act = 1'b0;
		rd_act = 1'b0;
		for (int k = 0; k < HD; k++)
		begin
			if (wr_hist_r[k] && (7'(k) >= wsel_dly) // RULE_07
				&& (7'(k) < (wr_chop_hist_r[k] ? wrel_chop : wrel_full))) // RULE_08
				wr_act = 1'b1;
			if (rd_hist_r[k] && (7'(k) >= rd_start)
				&& (7'(k) < rd_start + (rd_chop_hist_r[k] ? 7'h02 : 7'h04)
				+ xcyc + ycyc)) // RULE_21
				rd_act = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// termination selection

	always_comb
	begin
		if (rd_act)
		begin
			state_nxt = TERM_OFF; // RULE_03
			value_nxt = 3'h0;
		end
		else if (wr_act)
		begin
			state_nxt = TERM_WR; // RULE_20
			value_nxt = wr_val;
		end
		else if (nom_on)
		begin
			state_nxt = TERM_NOM; // RULE_06
			value_nxt = nom_val;
		end
		else if (park_val != 3'h0)
		begin
			state_nxt = TERM_PARK; // RULE_06
			value_nxt = park_val;
		end
		else
		begin
			state_nxt = TERM_OFF;
			value_nxt = 3'h0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= TERM_OFF;
			value_r <= 3'h0;
		end
		else
		begin
			case (state_nxt)
				TERM_OFF, TERM_PARK, TERM_NOM, TERM_WR: state_r <= state_nxt; // RULE_20
				default: state_r <= TERM_OFF;
			endcase
			value_r <= value_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// hold interval check

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hold_cnt_r <= 7'h00;
			hold_run_r <= 1'b0;
			hold_chop_r <= 1'b0;
		end
		else if (pin_rise || cmd_i.write)
		begin
			hold_cnt_r <= 7'h01; // RULE_02
			hold_run_r <= 1'b1;
			hold_chop_r <= cmd_chop;
		end
		else if (hold_run_r)
		begin
			if (pin_fall || hold_cnt_r >= hold_min)
				hold_run_r <= 1'b0;
			else
				hold_cnt_r <= hold_cnt_r + 7'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register port

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mode_one_r <= `MODE_ONE_RST;
			mode_two_r <= `MODE_TWO_RST;
			mode_five_r <= `MODE_FIVE_RST;
			latency_r <= `LATENCY_RST;
			config_r <= `CONFIG_RST;
		end
		else if (req_i.wr)
		begin
			case (req_i.addr)
				`REG_MODE_ONE: mode_one_r <= req_i.wdata[15:0];
				`REG_MODE_TWO: mode_two_r <= req_i.wdata[15:0];
				`REG_MODE_FIVE: mode_five_r <= req_i.wdata[15:0];
				`REG_LATENCY: latency_r <= req_i.wdata[19:0];
				`REG_CONFIG: config_r <= req_i.wdata[3:0];
				default: ;
			endcase
		end
	end

	// sticky hold violation, cleared by writing one; a new violation wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			hold_viol_r <= 1'b0;
		else if (hold_run_r && pin_fall && hold_cnt_r < hold_min && !cmd_i.write)
			hold_viol_r <= 1'b1; // RULE_02
		else if (req_i.wr && req_i.addr == `REG_STATUS && req_i.wdata[`STAT_HOLD_BIT])
			hold_viol_r <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_r <= 32'h0000_0000;
		else if (req_i.rd)
		begin
			case (req_i.addr)
				`REG_MODE_ONE: rdata_r <= {16'h0000, mode_one_r};
				`REG_MODE_TWO: rdata_r <= {16'h0000, mode_two_r};
				`REG_MODE_FIVE: rdata_r <= {16'h0000, mode_five_r};
				`REG_LATENCY: rdata_r <= {12'h000, latency_r};
				`REG_CONFIG: rdata_r <= {28'h0000000, config_r};
				`REG_STATUS: rdata_r <= {26'h0000000, hold_viol_r, ~cke_f_r, state_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
		else
			rdata_r <= 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign rdata_o = rdata_r;
	assign term_state_o = state_r;
	assign term_value_o = value_r;

endmodule : term_ctrl

`default_nettype wire

// ### test/ctrl_model.sv
// controller model driving the pin and clock enable
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishes of the bench
	input wire logic want_pin_i,
	input wire logic want_cke_i,
	// device pins
	output logic term_ctl_pin_o,
	output logic cke_o
);
	logic [3:0] hold_r;
	logic [3:0] exit_r;
	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i)
	begin
		cke_o <= rst_i || want_cke_i;
		if (rst_i)
			exit_r <= 4'h0;
		else if (want_cke_i && !cke_o)
			exit_r <= 4'h5;
		else if (exit_r != 4'h0)
			exit_r <= exit_r - 4'h1;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i || exit_r != 4'h0 || (want_cke_i && !cke_o))
			term_ctl_pin_o <= 1'b0;
		else if (term_ctl_pin_o && hold_r != 4'h0)
			hold_r <= hold_r - 4'h1;
		else if (cke_o && want_cke_i)
		begin
			term_ctl_pin_o <= want_pin_i;
			hold_r <= 4'h8;
		end
	end
endmodule : ctrl_model
`default_nettype wire

// ### test/term_ctrl_bench.sv
// self-checking bench for the termination control block
`timescale 1ns/1ps
`default_nettype none
module term_ctrl_bench
	import term_ctrl_pkg::*;
;
	typedef struct {int at; logic [31:0] d;} note_s;
	logic clk, rst, want_pin, want_cke, pin, cke, c;
	cmd_s cmd;
	reg_req_s req;
	logic [31:0] rdata;
	term_state_e state;
	logic [2:0] value;
	int cyc = 0, fails = 0, total_checks = 0, n, x, w, la, ls;
	note_s tq[$], rq[$];
	ctrl_model PART (.clk_i(clk), .rst_i(rst), .want_pin_i(want_pin), .want_cke_i(want_cke),
		.term_ctl_pin_o(pin), .cke_o(cke));
	term_ctrl DUT (.clk_i(clk), .rst_i(rst), .term_ctl_pin_i(pin), .cke_i(cke), .cmd_i(cmd),
		.req_i(req), .rdata_o(rdata), .term_state_o(state), .term_value_o(value));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task compare(logic [31:0] got, logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : compare
	task summarize();
		if (tq.size() > 0 || rq.size() > 0)
			fails++;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	always @(negedge clk)
	begin
		if (tq.size() > 0 && tq[0].at == cyc)
		begin
			compare({25'h0, state, value}, tq[0].d);
			void'(tq.pop_front());
		end
		if (rq.size() > 0 && rq[0].at == cyc)
		begin
			compare(rdata, rq[0].d);
			void'(rq.pop_front());
		end
		cyc++;
		if (cyc > 2000)
		begin
			fails++;
			summarize();
		end
	end
	task tick(int k);
		repeat (k) @(posedge clk);
	endtask : tick
	task reg_wr(logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : reg_wr
	task reg_rd(logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		req <= '{a, 32'h0, 1'b0, 1'b1};
		rq.push_back('{cyc + 1, d});
		@(posedge clk);
		req.rd <= 1'b0;
	endtask : reg_rd
	task pulse(logic wr, logic ch);
		@(posedge clk);
		cmd <= '{wr, !wr, ch};
		n = cyc;
		@(posedge clk);
		cmd <= '0;
	endtask : pulse
	task expect_term(int a, int b, term_state_e s, logic [2:0] v);
		for (int i = a; i <= b; i++)
			tq.push_back('{i, {25'h0, s, v}});
	endtask : expect_term
	task wait_state(term_state_e s, output int lat);
		lat = 0;
		while (state !== s && lat < 90)
		begin
			@(negedge clk);
			lat++;
		end
		compare({28'h0, state}, {28'h0, s});
	endtask : wait_state
	////////////////////////////////////////////////////////////////
	initial
	begin
		rst = 1'b1;
		want_pin = 1'b0;
		want_cke = 1'b1;
		cmd = '0;
		req = '0;
		void'($urandom(32'h3d93));
		tick(6);
		rst <= 1'b0;
		reg_rd(4'h0, 32'h1);
		reg_rd(4'h3, 32'h2c009);
		reg_rd(4'h9, 32'h0);
		reg_wr(4'h0, 32'h701);
		reg_wr(4'h1, 32'h600);
		reg_wr(4'h2, 32'h140);
		reg_wr(4'h9, 32'hffff);
		reg_rd(4'h1, 32'h600);
		$display("registers done");
		for (int k = 0; k < 8; k++)
		begin
			c = 1'($urandom);
			x = 2 + k[1];
			w = (c ? 4 : 6) + k[0];
			reg_wr(4'h4, {28'h0, k[2] ? 2'h1 : {c, 1'b0}, k[1], k[0]});
			pulse(1'b1, c);
			expect_term(n + 10 - x, n + 10 - x, TERM_PARK, 3'h5);
			expect_term(n + 11 - x, n + 10 + w, TERM_WR, 3'h3);
			expect_term(n + 11 + w, n + 11 + w, TERM_PARK, 3'h5);
			tick(14);
			pulse(1'b0, 1'b0);
			expect_term(n + 12 - x, n + 12 - x, TERM_PARK, 3'h5);
			w = (c && !k[2]) ? 2 : 0;
			expect_term(n + 13 - x, n + 16 + k[0] - w, TERM_OFF, 3'h0);
			expect_term(n + 17 + k[0] - w, n + 17 + k[0] - w, TERM_PARK, 3'h5);
			tick(20);
		end
		reg_wr(4'h4, 32'h0);
		$display("windows done");
		@(posedge clk);
		want_pin <= 1'b1;
		wait_state(TERM_NOM, ls);
		expect_term(cyc, cyc, TERM_NOM, 3'h7);
		pulse(1'b1, 1'b0);
		expect_term(n + 9, n + 16, TERM_WR, 3'h3);
		expect_term(n + 17, n + 17, TERM_NOM, 3'h7);
		tick(20);
		want_pin <= 1'b0;
		wait_state(TERM_PARK, la);
		reg_wr(4'h0, 32'h700);
		tick(4);
		want_pin <= 1'b1;
		wait_state(TERM_NOM, la);
		compare(32'(ls - la), 32'h6);
		tick(10);
		want_pin <= 1'b0;
		wait_state(TERM_PARK, la);
		$display("pin done");
		reg_wr(4'h2, 32'h160);
		want_pin <= 1'b1;
		wait_state(TERM_NOM, la);
		@(posedge clk);
		want_cke <= 1'b0;
		wait_state(TERM_PARK, la);
		expect_term(cyc, cyc + 9, TERM_PARK, 3'h5);
		tick(10);
		want_cke <= 1'b1;
		want_pin <= 1'b0;
		expect_term(cyc + 1, cyc + 8, TERM_PARK, 3'h5);
		tick(12);
		$display("power-down done");
		summarize();
	end
endmodule : term_ctrl_bench
`default_nettype wire

// ### test/term_ctrl_monitor.sv
// assertions on the termination control ports
`timescale 1ns/1ps
`default_nettype none
module term_ctrl_monitor
	import term_ctrl_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// inputs watched
	input wire logic term_ctl_pin_i,
	input wire cmd_s cmd_i,
	input wire reg_req_s req_i,
	// outputs watched
	input wire logic [31:0] rdata_o,
	input wire term_state_e term_state_o,
	input wire logic [2:0] term_value_o
);
	logic [6:0] pin_age_r;
	logic [6:0] wr_age_r;
	////////////////////////////////////////////////////////////////
	// cycles since pin high and since write
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pin_age_r <= 7'h7f;
		else if (term_ctl_pin_i)
			pin_age_r <= 7'h0;
		else if (pin_age_r != 7'h7f)
			pin_age_r <= pin_age_r + 7'h1;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wr_age_r <= 7'h7f;
		else if (cmd_i.write)
			wr_age_r <= 7'h0;
		else if (wr_age_r != 7'h7f)
			wr_age_r <= wr_age_r + 7'h1;
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence unmapped_rd;
		req_i.rd && req_i.addr > 4'h5;
	endsequence
	sequence read_cmd;
		cmd_i.read;
	endsequence
	a_reset_out: assert property ($fell(rst_i) |-> term_state_o == TERM_OFF && term_value_o == 3'h0)
		else $error("outputs not idle after reset");
	a_state_onehot: assert property ($onehot(term_state_o))
		else $error("state not one-hot");
	a_off_no_code: assert property (term_state_o == TERM_OFF |-> term_value_o == 3'h0)
		else $error("code while off");
	a_write_code: assert property (term_state_o == TERM_WR |-> !term_value_o[2] && term_value_o != 3'h0)
		else $error("bad write code");
	a_write_cause: assert property (term_state_o == TERM_WR |-> wr_age_r < 7'h48)
		else $error("write termination without write");
	a_nom_cause: assert property (term_state_o == TERM_NOM |-> pin_age_r < 7'h48)
		else $error("nominal without pin");
	a_read_quiet: assert property (read_cmd |-> ##[3:72] term_state_o == TERM_OFF)
		else $error("read did not disable termination");
	a_rdata_idle: assert property (!req_i.rd |=> rdata_o == 32'h0)
		else $error("read data without read");
	a_unmapped_rd: assert property (unmapped_rd |=> rdata_o == 32'h0)
		else $error("unmapped read not zero");
endmodule : term_ctrl_monitor
bind term_ctrl term_ctrl_monitor MON (.clk_i(clk_i), .rst_i(rst_i), .term_ctl_pin_i(term_ctl_pin_i),
	.cmd_i(cmd_i), .req_i(req_i), .rdata_o(rdata_o), .term_state_o(term_state_o),
	.term_value_o(term_value_o));
`default_nettype wire
